// File: design/pcr_pkg.sv
package pcr_pkg;

    // ----------------------------------------
    // Configuration space placement
    // ----------------------------------------
    localparam logic [7:0] CMD_STAT_OFF = 8'h04;

    // ----------------------------------------
    // Command field positions
    // ----------------------------------------
    localparam int CMD_INTR_PIN_MASK = 10;
    localparam int CMD_BACK_TO_BACK = 9;
    localparam int CMD_SYSERR_PIN_EN = 8;
    localparam int CMD_ADDR_STEP = 7;
    localparam int CMD_PARITY_RESP = 6;
    localparam int CMD_PALETTE_SNOOP = 5;
    localparam int CMD_WRITE_INVAL = 4;
    localparam int CMD_SPECIAL_CYCLE = 3;
    localparam int CMD_BUS_MASTER = 2;
    localparam int CMD_MEMORY_SPACE = 1;
    localparam int CMD_IO_SPACE = 0;

    // Only these command bits hold what software writes
    localparam logic [15:0] CMD_WR_MASK = 16'h055e;
    localparam logic [15:0] CMD_RESET = 16'h0000;

    // ----------------------------------------
    // Status field positions and values
    // ----------------------------------------
    localparam int ST_PARITY_DETECTED = 15;
    localparam int ST_SYSERR_SIGNALED = 14;
    localparam int ST_RCV_MASTER_ABORT = 13;
    localparam int ST_RCV_TARGET_ABORT = 12;
    localparam int ST_MASTER_PARITY = 8;
    localparam int ST_INTR_STATUS = 3;
    localparam logic [15:0] ST_W1C_MASK = 16'hf100;
    localparam logic [15:0] ST_RESET = 16'h0000;
    // Medium decode timing in bits 10-9, capability list in bit 4
    localparam logic [15:0] ST_FIXED = 16'h0210;

    // ----------------------------------------
    // Configuration request carrier
    // ----------------------------------------
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } pcr_cfg_req_t;

endpackage

// File: design/pcr_sync.sv
`timescale 1ns/100ps
`default_nettype none

module pcr_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Asynchronous level and its synchronised copy
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync,
    // Unused; both stages reset to zero
    input wire logic [W-1:0] i_unused_dummy
);

    logic [W-1:0] meta_q;

    // Two stages; the first is read by the second alone
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end

endmodule

`default_nettype wire

// File: design/pcr_cfg_port.sv
`timescale 1ns/100ps
`default_nettype none

module pcr_cfg_port (
    // PCI clock domain
    input wire logic i_pci_clk,
    input wire logic i_nrst,
    // Configuration access from the host bus logic
    input wire logic i_cfg_req,
    input wire pcr_pkg::pcr_cfg_req_t i_cfg,
    output logic o_cfg_busy,
    output logic o_cfg_ack,
    output logic [31:0] o_cfg_rdata,
    // Handshake with the core domain
    output pcr_pkg::pcr_cfg_req_t o_hold,
    output logic o_req_tgl,
    input wire logic i_ack_tgl,
    input wire logic [31:0] i_rdata
);

    logic ack_s;
    logic ack_seen_q;
    wire take = i_cfg_req & ~o_cfg_busy;
    wire done = ack_s ^ ack_seen_q;

    // Acknowledge toggle comes from the core clock
    pcr_sync #(.W(1)) u_ack_sync (
        .i_clk(i_pci_clk),
        .i_nrst(i_nrst),
        .i_async(i_ack_tgl),
        .o_sync(ack_s),
        .i_unused_dummy(1'b0)
    );

    // Hold stays still while busy, so the core may read it freely
    always_ff @(posedge i_pci_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_hold <= '0;
            o_req_tgl <= 1'b0;
            o_cfg_busy <= 1'b0;
            o_cfg_ack <= 1'b0;
            o_cfg_rdata <= 32'h0000_0000;
            ack_seen_q <= 1'b0;
        end else begin
            ack_seen_q <= ack_s;
            o_cfg_ack <= done;
            if (take) begin
                o_hold <= i_cfg;
                o_req_tgl <= ~o_req_tgl;
                o_cfg_busy <= 1'b1;
            end else if (done) begin
                o_cfg_busy <= 1'b0;
                o_cfg_rdata <= i_rdata;
            end
        end
    end

endmodule

`default_nettype wire

// File: design/pcr_regs.sv
// Notes on behaviour
// R01 - Command bit 10 set keeps the interrupt pin driver off; clear lets it assert.
// R02 - Command bit 9 reads zero; no fast back-to-back transfers are ever made.
// R03 - Command bit 8 gates internal system errors onto the system error pin.
// R04 - Command bit 7 reads zero; address stepping is never done.
// R05 - Bit 6 clear: parity errors only flag status; set: parity pin asserted too.
// R06 - Command bit 5 palette snoop always reads zero.
// R07 - Memory write and invalidate may be used only while command bit 4 is set.
// R08 - Special cycles are ignored unless command bit 3 is set.
// R09 - Bus master transactions start only while command bit 2 is set.
// R10 - Memory accesses are claimed only while command bit 1 is set.
// R11 - Command bit 0 reads zero; I/O transactions are never claimed.
// R12 - Command bits 15 to 11 always read zero.
// R13 - Status bit 15 sets on any detected parity error, reported or not.
// R14 - Interrupt pin low when status bit 3 set and mask clear; mask leaves status.
// R15 - Status bit 14 sets whenever the system error pin was driven.
// R16 - Status bit 8 sets on parity pin seen, while master, with response enabled.
// R17 - Writes to fixed or reserved command bits are dropped; reads give fixed values.
`timescale 1ns/100ps
`default_nettype none

module pcr_regs (
    // Clocks and reset
    input wire logic i_ref_clk,
    input wire logic i_pci_clk,
    input wire logic i_nrst,
    // Configuration access, PCI clock
    input wire logic i_cfg_req,
    input wire pcr_pkg::pcr_cfg_req_t i_cfg,
    output logic o_cfg_busy,
    output logic o_cfg_ack,
    output logic [31:0] o_cfg_rdata,
    // Back end events and requests, reference clock
    input wire logic i_int_pending,
    input wire logic i_serr_event,
    input wire logic i_par_err_event,
    input wire logic i_master_active,
    input wire logic i_rcv_master_abort,
    input wire logic i_rcv_target_abort,
    input wire logic i_master_req,
    input wire logic i_mwi_req,
    input wire logic i_mem_hit,
    input wire logic i_io_hit,
    input wire logic i_special_cycle,
    // Gated requests toward the bus engines
    output logic o_master_start,
    output logic o_mwi_start,
    output logic o_mem_claim,
    output logic o_io_claim,
    output logic o_special_cycle_take,
    output logic o_back_to_back,
    output logic o_address_stepping,
    // Register views
    output logic [15:0] o_command,
    output logic [15:0] o_status,
    // Parity error pin, two-way
    input wire logic i_parity_error_pin_n,
    output logic o_parity_error_pin_n,
    output logic o_parity_error_pin_n_oe,
    // Interrupt pin, open drain
    output logic o_interrupt_a_pin_n,
    output logic o_interrupt_a_pin_n_oe,
    // System error pin, open drain
    output logic o_system_error_pin_n,
    output logic o_system_error_pin_n_oe
);

    // ----------------------------------------
    // Configuration crossing
    // ----------------------------------------
    pcr_pkg::pcr_cfg_req_t hold;
    logic req_tgl;
    logic req_s;
    logic req_seen_q;
    logic ack_tgl_q;
    logic [31:0] rdata_q;

    // Port logic lives on the PCI clock
    pcr_cfg_port u_port (
        .i_pci_clk(i_pci_clk),
        .i_nrst(i_nrst),
        .i_cfg_req(i_cfg_req),
        .i_cfg(i_cfg),
        .o_cfg_busy(o_cfg_busy),
        .o_cfg_ack(o_cfg_ack),
        .o_cfg_rdata(o_cfg_rdata),
        .o_hold(hold),
        .o_req_tgl(req_tgl),
        .i_ack_tgl(ack_tgl_q),
        .i_rdata(rdata_q)
    );

    // Request toggle enters the reference domain
    pcr_sync #(.W(1)) u_req_sync (
        .i_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_async(req_tgl),
        .o_sync(req_s),
        .i_unused_dummy(1'b0)
    );

    // Parity pin comes from the bus, so it is synchronised too
    logic perr_pin_s;
    pcr_sync #(.W(1)) u_perr_sync (
        .i_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_async(~i_parity_error_pin_n),
        .o_sync(perr_pin_s),
        .i_unused_dummy(1'b0)
    );

    // ----------------------------------------
    // Access decode
    // ----------------------------------------
    logic [15:0] cmd_q;
    logic [15:0] cmd_d;
    logic [15:0] sticky_q;
    logic [15:0] sticky_d;
    logic int_stat_q;

    // Hold is stable from the toggle edge until the ack returns
    wire cfg_go = req_s ^ req_seen_q;
    wire cfg_hit = (hold.addr[7:2] == pcr_pkg::CMD_STAT_OFF[7:2]);
    wire cfg_wr = cfg_go & cfg_hit & hold.wr;

    // Byte enables widened to command and status lanes
    wire [15:0] cmd_lane = {{8{hold.be[1]}}, {8{hold.be[0]}}};
    wire [15:0] st_lane = {{8{hold.be[3]}}, {8{hold.be[2]}}};

    // ----------------------------------------
    // Command register
    // ----------------------------------------
    // Only writable bits take data; the rest stay at zero
    wire [15:0] cmd_wmask = cmd_lane & pcr_pkg::CMD_WR_MASK; // R17 R12
    assign cmd_d = cfg_wr ? ((cmd_q & ~cmd_wmask) | (hold.wdata[15:0] & cmd_wmask)) : cmd_q;

    // Named command fields
    wire intr_pin_mask = cmd_q[pcr_pkg::CMD_INTR_PIN_MASK];
    wire syserr_pin_enable = cmd_q[pcr_pkg::CMD_SYSERR_PIN_EN];
    wire parity_response_enable = cmd_q[pcr_pkg::CMD_PARITY_RESP];
    wire write_invalidate_enable = cmd_q[pcr_pkg::CMD_WRITE_INVAL];
    wire special_cycle_monitor = cmd_q[pcr_pkg::CMD_SPECIAL_CYCLE];
    wire bus_master_enable = cmd_q[pcr_pkg::CMD_BUS_MASTER];
    wire memory_space_enable = cmd_q[pcr_pkg::CMD_MEMORY_SPACE];

    // Hardwired fields, kept as named zeros for the read view
    wire back_to_back_enable = 1'b0; // R02
    wire address_stepping_ctrl = 1'b0; // R04
    wire palette_snoop_enable = 1'b0; // R06
    wire io_space_enable = 1'b0; // R11

    // Read view rebuilt from fields so a stray bit cannot leak out
    wire [15:0] cmd_view = {
        5'h00,
        intr_pin_mask,
        back_to_back_enable,
        syserr_pin_enable,
        address_stepping_ctrl,
        parity_response_enable,
        palette_snoop_enable,
        write_invalidate_enable,
        special_cycle_monitor,
        bus_master_enable,
        memory_space_enable,
        io_space_enable
    }; // R12

    // ----------------------------------------
    // Error pin decisions
    // ----------------------------------------
    // Parity pin asserted only with response enabled
    wire perr_drive = i_par_err_event & parity_response_enable; // R05
    // System error leaves the chip only when its driver is enabled
    wire serr_drive = i_serr_event & syserr_pin_enable; // R03
    // Our own drive counts as well as a pin seen low
    wire master_parity_hit = (perr_drive | perr_pin_s) & i_master_active
        & parity_response_enable; // R16

    // ----------------------------------------
    // Status register
    // ----------------------------------------
    wire [15:0] st_set;
    assign st_set[pcr_pkg::ST_PARITY_DETECTED] = i_par_err_event; // R13
    assign st_set[pcr_pkg::ST_SYSERR_SIGNALED] = serr_drive; // R15
    assign st_set[pcr_pkg::ST_RCV_MASTER_ABORT] = i_rcv_master_abort;
    assign st_set[pcr_pkg::ST_RCV_TARGET_ABORT] = i_rcv_target_abort;
    assign st_set[11:9] = 3'h0;
    assign st_set[pcr_pkg::ST_MASTER_PARITY] = master_parity_hit; // R16
    assign st_set[7:0] = 8'h00;

    // Write one to clear; a set in the same cycle wins
    wire [15:0] st_clr = cfg_wr ? (hold.wdata[31:16] & st_lane & pcr_pkg::ST_W1C_MASK) : 16'h0000;
    assign sticky_d = ((sticky_q & ~st_clr) | st_set) & pcr_pkg::ST_W1C_MASK;

    // Interrupt status follows the back end; the mask does not touch it
    wire [15:0] int_view = {12'h000, int_stat_q, 3'h0}; // R14
    wire [15:0] st_view = sticky_q | pcr_pkg::ST_FIXED | int_view;

    // Only the command and status word is held here
    wire [31:0] rd_word = cfg_hit ? {st_view, cmd_view} : 32'h0000_0000;

    // ----------------------------------------
    // Reference clock state
    // ----------------------------------------
    // Crossing state and the two registers
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            req_seen_q <= 1'b0;
            ack_tgl_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            cmd_q <= pcr_pkg::CMD_RESET;
            sticky_q <= pcr_pkg::ST_RESET;
            int_stat_q <= 1'b0;
        end else begin
            req_seen_q <= req_s;
            cmd_q <= cmd_d;
            sticky_q <= sticky_d;
            int_stat_q <= i_int_pending;
            if (cfg_go) begin
                // Read data shows the state before this write
                rdata_q <= rd_word;
                ack_tgl_q <= ~ack_tgl_q;
            end
        end
    end

    // ----------------------------------------
    // Gated requests
    // ----------------------------------------
    // One cycle of latency keeps every output on a flip-flop
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_master_start <= 1'b0;
            o_mwi_start <= 1'b0;
            o_mem_claim <= 1'b0;
            o_io_claim <= 1'b0;
            o_special_cycle_take <= 1'b0;
            o_back_to_back <= 1'b0;
            o_address_stepping <= 1'b0;
        end else begin
            o_master_start <= i_master_req & bus_master_enable; // R09
            // Invalidate writes are master writes, so both bits gate them
            o_mwi_start <= i_mwi_req & bus_master_enable & write_invalidate_enable; // R07
            o_mem_claim <= i_mem_hit & memory_space_enable; // R10
            o_io_claim <= i_io_hit & io_space_enable; // R11
            o_special_cycle_take <= i_special_cycle & special_cycle_monitor; // R08
            o_back_to_back <= back_to_back_enable; // R02
            o_address_stepping <= address_stepping_ctrl; // R04
        end
    end

    // ----------------------------------------
    // Register views and pins
    // ----------------------------------------
    // Pins are low while driven; value and enable both registered
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_command <= 16'h0000;
            o_status <= 16'h0000;
            o_parity_error_pin_n <= 1'b1;
            o_parity_error_pin_n_oe <= 1'b0;
            o_interrupt_a_pin_n <= 1'b1;
            o_interrupt_a_pin_n_oe <= 1'b0;
            o_system_error_pin_n <= 1'b1;
            o_system_error_pin_n_oe <= 1'b0;
        end else begin
            o_command <= cmd_view;
            o_status <= st_view;
            o_parity_error_pin_n <= ~perr_drive; // R05
            o_parity_error_pin_n_oe <= perr_drive; // R05
            o_interrupt_a_pin_n <= ~(int_stat_q & ~intr_pin_mask); // R01 R14
            o_interrupt_a_pin_n_oe <= int_stat_q & ~intr_pin_mask; // R01 R14
            o_system_error_pin_n <= ~serr_drive; // R03
            o_system_error_pin_n_oe <= serr_drive; // R03
        end
    end

endmodule

`default_nettype wire

// File: sim/pcr_regs_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port checks, core clock domain
// ----------------------------------------
module pcr_regs_checker (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // Back end inputs
    input wire logic i_int_pending,
    input wire logic i_serr_event,
    input wire logic i_par_err_event,
    input wire logic i_master_req,
    input wire logic i_mwi_req,
    input wire logic i_mem_hit,
    input wire logic i_special_cycle,
    // Design outputs
    input wire logic o_master_start,
    input wire logic o_mwi_start,
    input wire logic o_mem_claim,
    input wire logic o_io_claim,
    input wire logic o_special_cycle_take,
    input wire logic o_back_to_back,
    input wire logic o_address_stepping,
    input wire logic [15:0] o_command,
    input wire logic [15:0] o_status,
    input wire logic o_parity_error_pin_n,
    input wire logic o_interrupt_a_pin_n,
    input wire logic o_system_error_pin_n
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    // o_command trails the live register by one cycle, the same as the gating flop
    property p_fixed; (o_command & ~pcr_pkg::CMD_WR_MASK) == 16'h0000; endproperty
    a_fixed: assert property (p_fixed) else $error("fixed command bit set");
    property p_never; !o_io_claim && !o_back_to_back && !o_address_stepping; endproperty
    a_never: assert property (p_never) else $error("unsupported action seen");
    property p_master; o_master_start == ($past(i_master_req) && o_command[2]); endproperty
    a_master: assert property (p_master) else $error("master start gating");
    property p_mwi; o_mwi_start == ($past(i_mwi_req) && o_command[2] && o_command[4]); endproperty
    a_mwi: assert property (p_mwi) else $error("write invalidate gating");
    property p_mem; o_mem_claim == ($past(i_mem_hit) && o_command[1]); endproperty
    a_mem: assert property (p_mem) else $error("memory claim gating");
    property p_spc; o_special_cycle_take == ($past(i_special_cycle) && o_command[3]); endproperty
    a_spc: assert property (p_spc) else $error("special cycle gating");
    property p_serr; !o_system_error_pin_n == ($past(i_serr_event) && o_command[8]); endproperty
    a_serr: assert property (p_serr) else $error("system error pin gating");
    property p_serr_flag; $fell(o_system_error_pin_n) |-> ##[1:2] o_status[14]; endproperty
    a_serr_flag: assert property (p_serr_flag) else $error("system error flag missing");
    property p_par_flag; $past(i_par_err_event) |-> ##[0:2] o_status[15]; endproperty
    a_par_flag: assert property (p_par_flag) else $error("parity flag missing");
    property p_par_quiet; $past(i_par_err_event) && !o_command[6] |-> o_parity_error_pin_n; endproperty
    a_par_quiet: assert property (p_par_quiet) else $error("parity pin driven while off");
    property p_intr; !o_interrupt_a_pin_n == ($past(i_int_pending, 2) && !o_command[10]); endproperty
    a_intr: assert property (p_intr) else $error("interrupt pin gating");
    property p_mflag; $rose(o_status[8]) |-> $past(o_command[6]); endproperty
    a_mflag: assert property (p_mflag) else $error("master parity flag without response");
    c_master: cover property (o_master_start);
    c_serr: cover property (!o_system_error_pin_n);
    c_intr: cover property (!o_interrupt_a_pin_n);
endmodule
bind pcr_regs pcr_regs_checker chk (.i_ref_clk, .i_nrst, .i_int_pending, .i_serr_event, .i_par_err_event,
    .i_master_req, .i_mwi_req, .i_mem_hit, .i_special_cycle, .o_master_start, .o_mwi_start, .o_mem_claim,
    .o_io_claim, .o_special_cycle_take, .o_back_to_back, .o_address_stepping, .o_command, .o_status,
    .o_parity_error_pin_n, .o_interrupt_a_pin_n, .o_system_error_pin_n);
`default_nettype wire

// File: sim/pcr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Host side of the configuration port
// ----------------------------------------
module pcr_host_model (
    // PCI clock
    input wire logic i_pci_clk,
    // Request toward the device
    output var logic o_cfg_req,
    output var pcr_pkg::pcr_cfg_req_t o_cfg,
    // Answer from the device
    input wire logic i_cfg_busy,
    input wire logic i_cfg_ack,
    input wire logic [31:0] i_cfg_rdata
);
    int gap = 0;
    initial begin
        o_cfg_req = 1'b0;
        o_cfg = '0;
    end
    // One access; gap idle cycles first make the host start its request late
    task automatic access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                          input logic [31:0] wd, output logic [31:0] rd);
        int n;
        logic b;
        repeat (gap) @(posedge i_pci_clk);
        #1;
        o_cfg_req = 1'b1;
        o_cfg = '{wr, addr, be, wd};
        n = 0;
        // Busy is read before the edge, so the take edge is known without racing the port
        do begin
            b = i_cfg_busy;
            @(posedge i_pci_clk);
            #1;
            n++;
        end while (b !== 1'b0 && n < 50);
        o_cfg_req = 1'b0;
        // Released fields show junk, never the old value
        o_cfg = ~o_cfg;
        n = 0;
        while (i_cfg_ack !== 1'b1 && n < 50) begin
            @(posedge i_pci_clk);
            #1;
            n++;
        end
        // A lost answer gives unknown data, so a later compare trips
        rd = (i_cfg_ack === 1'b1) ? i_cfg_rdata : 32'hxxxx_xxxx;
    endtask
endmodule
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic i_ref_clk, i_pci_clk, i_nrst, i_cfg_req, o_cfg_busy, o_cfg_ack;
    pcr_pkg::pcr_cfg_req_t i_cfg;
    logic [31:0] o_cfg_rdata, rd;
    logic i_int_pending, i_serr_event, i_par_err_event, i_master_active, i_rcv_master_abort, i_rcv_target_abort;
    logic i_master_req, i_mwi_req, i_mem_hit, i_io_hit, i_special_cycle, host_perr_n, serr_seen, mpar_seen;
    logic o_master_start, o_mwi_start, o_mem_claim, o_io_claim, o_special_cycle_take, o_back_to_back;
    logic o_address_stepping, o_parity_error_pin_n, o_parity_error_pin_n_oe, o_interrupt_a_pin_n;
    logic o_interrupt_a_pin_n_oe, o_system_error_pin_n, o_system_error_pin_n_oe;
    logic [15:0] o_command, o_status, cmd;
    logic [15:0] cmd_tab [8] = '{16'h0000, 16'h0040, 16'h0100, 16'h0400, 16'h0014, 16'h0008, 16'h0002, 16'hffff};
    int bad_count, samples_checked;
    // Pulled-up parity line: low if either party drives it low
    wire perr_wire = (o_parity_error_pin_n_oe && !o_parity_error_pin_n) ? 1'b0 : host_perr_n;

    pcr_regs dut (.i_ref_clk, .i_pci_clk, .i_nrst, .i_cfg_req, .i_cfg, .o_cfg_busy, .o_cfg_ack, .o_cfg_rdata,
        .i_int_pending, .i_serr_event, .i_par_err_event, .i_master_active, .i_rcv_master_abort,
        .i_rcv_target_abort, .i_master_req, .i_mwi_req, .i_mem_hit, .i_io_hit, .i_special_cycle, .o_master_start,
        .o_mwi_start, .o_mem_claim, .o_io_claim, .o_special_cycle_take, .o_back_to_back, .o_address_stepping,
        .o_command, .o_status, .i_parity_error_pin_n(perr_wire), .o_parity_error_pin_n, .o_parity_error_pin_n_oe,
        .o_interrupt_a_pin_n, .o_interrupt_a_pin_n_oe, .o_system_error_pin_n, .o_system_error_pin_n_oe);
    pcr_host_model host (.i_pci_clk, .o_cfg_req(i_cfg_req), .o_cfg(i_cfg), .i_cfg_busy(o_cfg_busy),
        .i_cfg_ack(o_cfg_ack), .i_cfg_rdata(o_cfg_rdata));

    // ----------------------------------------
    // Clocks, unrelated in phase
    // ----------------------------------------
    initial begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        i_pci_clk = 1'b0;
        #13;
        forever #80 i_pci_clk = ~i_pci_clk;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // Returns 1 ns after a core edge, so inputs set next move then
    task automatic ref_cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic end_of_test;
        $display("checked %0d, wrong %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Whole run needs about 15 us; a hang is cut well beyond that
    initial begin
        #500000;
        bad_count++;
        $display("watchdog expired");
        end_of_test();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        {i_int_pending, i_serr_event, i_par_err_event, i_master_active, i_rcv_master_abort} = '0;
        {i_rcv_target_abort, i_master_req, i_mwi_req, i_mem_hit, i_io_hit, i_special_cycle} = '0;
        {host_perr_n, serr_seen, mpar_seen, i_nrst} = 4'h8;
        bad_count = 0;
        samples_checked = 0;
        repeat (5) @(posedge i_ref_clk);
        #1 i_nrst = 1'b1;
        repeat (3) @(posedge i_pci_clk);
        host.access(1'b0, 8'h04, 4'hf, 32'h0000_0000, rd);
        chk("reset view", rd, 32'h0210_0000);
        host.access(1'b1, 8'h08, 4'hf, 32'hffff_ffff, rd);
        host.access(1'b0, 8'h08, 4'hf, 32'h0000_0000, rd);
        chk("unmapped", rd, 32'h0000_0000);
        $display("test reset and unmapped done");
        // Control bits 6, 8, 10, 3 and 1 each on its own, bits 2 and 4 together, then all written high
        {i_master_req, i_mwi_req, i_mem_hit, i_io_hit, i_special_cycle, i_int_pending, i_master_active} = 7'h7f;
        for (int i = 0; i < 8; i++) begin
            cmd = cmd_tab[i];
            host.gap = i % 3;
            host.access(1'b1, 8'h04, 4'h3, {16'h0000, cmd}, rd);
            ref_cyc(3);
            chk("command", o_command, cmd & 16'h055e);
            chk("master", o_master_start, cmd[2]);
            chk("mwi", o_mwi_start, cmd[2] & cmd[4]);
            chk("mem claim", o_mem_claim, cmd[1]);
            chk("special", o_special_cycle_take, cmd[3]);
            chk("io claim", {o_io_claim, o_back_to_back, o_address_stepping}, 0);
            chk("intr pin", {o_interrupt_a_pin_n, o_interrupt_a_pin_n_oe}, {cmd[10], !cmd[10]});
            chk("intr status", o_status[3], 1);
            {i_serr_event, i_par_err_event} = 2'b11;
            ref_cyc(1);
            {i_serr_event, i_par_err_event} = 2'b00;
            chk("serr pin", {o_system_error_pin_n, o_system_error_pin_n_oe}, {!cmd[8], cmd[8]});
            chk("parity pin", {o_parity_error_pin_n, o_parity_error_pin_n_oe}, {!cmd[6], cmd[6]});
            ref_cyc(4);
            serr_seen = serr_seen | cmd[8];
            mpar_seen = mpar_seen | cmd[6];
            chk("parity flag", o_status[15], 1);
            chk("serr flag", o_status[14], serr_seen);
            chk("master parity flag", o_status[8], mpar_seen);
        end
        $display("test command gating done");
        {i_rcv_master_abort, i_rcv_target_abort} = 2'b11;
        ref_cyc(1);
        {i_rcv_master_abort, i_rcv_target_abort} = 2'b00;
        ref_cyc(3);
        host.access(1'b0, 8'h04, 4'hf, 32'h0000_0000, rd);
        chk("sticky view", rd, 32'hf318_055e);
        host.access(1'b1, 8'h04, 4'hc, 32'hffff_0000, rd);
        host.access(1'b0, 8'h04, 4'hf, 32'h0000_0000, rd);
        chk("cleared view", rd, 32'h0218_055e);
        i_int_pending = 1'b0;
        ref_cyc(4);
        chk("status idle", o_status, 16'h0210);
        // Host pulls the parity line; the flag also needs the master role
        {host_perr_n, i_master_active} = 2'b00;
        ref_cyc(5);
        chk("parity line, not master", o_status[8], 0);
        i_master_active = 1'b1;
        ref_cyc(5);
        chk("parity line, master", o_status[8], 1);
        host_perr_n = 1'b1;
        $display("test status clear done");
        end_of_test();
    end
endmodule
`default_nettype wire
